// ### rtl/egrx_map.svh
/*
 * Constants of the external receive GMII block: register port map, control
 * and status bit positions, management frame layout and sync counts.
 * Assumes inclusion by bare name from the block's package and top module.
 */
`ifndef EGRX_MAP_SVH
`define EGRX_MAP_SVH

// ==========================================================================
// Register port
// ==========================================================================
`define EGRX_A_CTRL      4'h0
`define EGRX_A_STAT      4'h1
`define EGRX_B_ISO       0
`define EGRX_B_UNI       1
`define EGRX_B_SYNC      0
`define EGRX_B_LINK      1
`define EGRX_B_SD        2
`define EGRX_ISO_RST     1'b1
`define EGRX_UNI_RST     1'b0

// ==========================================================================
// Management frame
// ==========================================================================
`define EGRX_M_CTRL      5'h00
`define EGRX_M_STAT      5'h01
`define EGRX_MB_ISO      10
`define EGRX_MB_UNI      5
`define EGRX_MB_LINK     2
`define EGRX_OP_RD       2'h2
`define EGRX_OP_WR       2'h1
`define EGRX_PRE_LAST    5'h1f
`define EGRX_HDR_LAST    5'h0b
`define EGRX_TA_LAST     5'h01
`define EGRX_DAT_LAST    5'h11

// ==========================================================================
// Synchronisation
// ==========================================================================
`define EGRX_COMMAS      2'h3

`endif

// ### rtl/egrx_pkg.sv
/*
 * Types of the external receive GMII block.
 * Assumes the constants header is available on the include path.
 */
package egrx_pkg;
    `include "egrx_map.svh"

    // ======================================================================
    // Carriers and states
    // ======================================================================
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [7:0] data;
    } egrx_gmii_s;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [7:0] data;
    } egrx_tx_s;

    typedef enum logic [1:0] {
        EGRX_LOSS = 2'b00,
        EGRX_ACQ  = 2'b01,
        EGRX_SYNC = 2'b10
    } egrx_sync_e;

    typedef enum logic [2:0] {
        EGRX_M_IDLE = 3'b000,
        EGRX_M_HDR  = 3'b001,
        EGRX_M_RD   = 3'b010,
        EGRX_M_WR   = 3'b011,
        EGRX_M_SKIP = 3'b100
    } egrx_mdio_e;
endpackage

// ### rtl/egrx_top.sv
/*
 * External receive GMII forwarding with link gating, isolate control,
 * receive sync tracking and a management slave on its own clock.
 * Assumes PCS and MAC-side transmit inputs are already on core_clk and the
 * management station drives mdio on the falling edge of mdc.
 */
// Function
// - Every receive GMII output leaves through an output flip-flop.
// - Forwarded receive clock comes from a DDR output register pair.
// - Forwarded clock is inverted so its rise centres in the data eye.
// - All receive logic runs on the single core clock.
// - Core clock is 125 MHz.
// - Transmission blocked until link, unless one-way override is set.
// - Isolate is set after reset; no transfer until software clears it.
// - While isolated the external GMII outputs are released.
// - Status bit 0 shows sync, bit 1 shows link up.
// - Optical presence low holds sync machine in loss of sync.
// - Management frames answered only when address matches address pins.
`timescale 1ns/1ns
`include "egrx_map.svh"
module egrx_top
    import egrx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire egrx_gmii_s  pcs_rx,
    input  wire logic        comma_det,
    input  wire logic        code_err,
    input  wire logic        an_enable,
    input  wire logic        an_complete,
    input  wire logic        signal_detect,
    input  wire egrx_tx_s    mac_tx,
    output egrx_tx_s         pcs_tx,
    output egrx_gmii_s       gmii_rx,
    output logic             gmii_rx_oe,
    output logic             gmii_rx_clk,
    output logic             gmii_rx_clk_oe,
    output logic [1:0]       status_vec,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe,
    input  wire logic [4:0]  phyad
);

    // ======================================================================
    // Core domain state
    // ======================================================================
    logic        iso_q, uni_q, sd_s1, sd_s2;
    egrx_sync_e  sync_q;
    logic [1:0]  comma_q;
    logic        link_w;
    logic        tog_s1, tog_s2, tog_s3;
    egrx_gmii_s  gmii_rx_q;
    egrx_tx_s    pcs_tx_q;
    logic        rx_oe_q, clk_oe_q, clk_rise_q, clk_fall_q;
    logic [1:0]  status_q;
    logic [15:0] rdata_q;

    // Management domain state
    logic        mrst_s1, mrst_q;
    egrx_mdio_e  mst_q;
    logic [4:0]  mcnt_q;
    logic [15:0] msh_q;
    logic [4:0]  mreg_q;
    logic [15:0] mwdata_q;
    logic        mtog_q, hit_q, mdo_q, mdoe_q;
    logic [4:0]  pad_s1, pad_s2;
    logic [2:0]  lvl_s1, lvl_s2;
    logic [11:0] hdr_w;

    assign link_w = (sync_q == EGRX_SYNC) && (an_complete || !an_enable);

    // ======================================================================
    // Control bits from both register port and management writes
    // ======================================================================
    always_ff @(posedge core_clk) begin
        if (srst) begin
            iso_q <= `EGRX_ISO_RST;
            uni_q <= `EGRX_UNI_RST;
        end else if (reg_wr && reg_addr == `EGRX_A_CTRL) begin
            iso_q <= reg_wdata[`EGRX_B_ISO];
            uni_q <= reg_wdata[`EGRX_B_UNI];
        end else if (tog_s2 != tog_s3 && mreg_q == `EGRX_M_CTRL) begin
            iso_q <= mwdata_q[`EGRX_MB_ISO];
            uni_q <= mwdata_q[`EGRX_MB_UNI];
        end
    end

    // Write event from the management clock; data are quiet by then.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= mtog_q;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sd_s1 <= 1'b0;
            sd_s2 <= 1'b0;
        end else begin
            sd_s1 <= signal_detect;
            sd_s2 <= sd_s1;
        end
    end

    // ======================================================================
    // Receive synchronisation
    // ======================================================================
    always_ff @(posedge core_clk) begin
        if (srst || !sd_s2) begin
            sync_q  <= EGRX_LOSS;
            comma_q <= 2'h0;
        end else begin
            case (sync_q)
                EGRX_LOSS: begin
                    if (comma_det) begin
                        sync_q  <= EGRX_ACQ;
                        comma_q <= 2'h1;
                    end
                end
                EGRX_ACQ: begin
                    if (code_err) begin
                        sync_q <= EGRX_LOSS;
                    end else if (comma_det) begin
                        comma_q <= comma_q + 2'h1;
                        if (comma_q + 2'h1 == `EGRX_COMMAS) begin
                            sync_q <= EGRX_SYNC;
                        end
                    end
                end
                EGRX_SYNC: begin
                    if (code_err) begin
                        sync_q <= EGRX_LOSS;
                    end
                end
                default: sync_q <= EGRX_LOSS;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_q <= 2'h0;
        end else begin
            status_q[`EGRX_B_SYNC] <= (sync_q == EGRX_SYNC);
            status_q[`EGRX_B_LINK] <= link_w;
        end
    end

    // ======================================================================
    // Data paths, output flip-flops and forwarded clock
    // ======================================================================
    always_ff @(posedge core_clk) begin
        if (srst || iso_q) begin
            gmii_rx_q <= '0;
            rx_oe_q   <= 1'b0;
            clk_oe_q  <= 1'b0;
        end else begin
            gmii_rx_q <= pcs_rx;
            rx_oe_q   <= 1'b1;
            clk_oe_q  <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || iso_q || !(link_w || uni_q)) begin
            pcs_tx_q <= '0;
        end else begin
            pcs_tx_q <= mac_tx;
        end
    end

    // DDR pair: low in the high half, high in the low half of core_clk.
    always_ff @(posedge core_clk) begin
        clk_rise_q <= 1'b0;
    end

    always_ff @(negedge core_clk) begin
        clk_fall_q <= 1'b1;
    end

    assign gmii_rx_clk = core_clk ? clk_rise_q : clk_fall_q;

    // ======================================================================
    // Register port
    // ======================================================================
    always_ff @(posedge core_clk) begin
        if (srst || !reg_rd) begin
            rdata_q <= 16'h0000;
        end else if (reg_addr == `EGRX_A_CTRL) begin
            rdata_q <= 16'h0000;
            rdata_q[`EGRX_B_ISO] <= iso_q;
            rdata_q[`EGRX_B_UNI] <= uni_q;
        end else if (reg_addr == `EGRX_A_STAT) begin
            rdata_q <= 16'h0000;
            rdata_q[`EGRX_B_SYNC] <= status_q[`EGRX_B_SYNC];
            rdata_q[`EGRX_B_LINK] <= status_q[`EGRX_B_LINK];
            rdata_q[`EGRX_B_SD]   <= sd_s2;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign gmii_rx        = gmii_rx_q;
    assign gmii_rx_oe     = rx_oe_q;
    assign gmii_rx_clk_oe = clk_oe_q;
    assign pcs_tx         = pcs_tx_q;
    assign status_vec     = status_q;
    assign reg_rdata      = rdata_q;
    assign mdio_o         = mdo_q;
    assign mdio_oe        = mdoe_q;

    // ======================================================================
    // Management slave on mdc
    // ======================================================================
    always_ff @(posedge mdc) begin
        mrst_s1 <= srst;
        mrst_q  <= mrst_s1;
        pad_s1  <= phyad;
        pad_s2  <= pad_s1;
        lvl_s1  <= {status_q[`EGRX_B_LINK], uni_q, iso_q};
        lvl_s2  <= lvl_s1;
    end

    assign hdr_w = {msh_q[10:0], mdio_i};

    always_ff @(posedge mdc) begin
        if (mrst_q) begin
            mst_q  <= EGRX_M_IDLE;
            mcnt_q <= 5'h00;
            msh_q  <= 16'h0000;
            mreg_q <= 5'h00;
            hit_q  <= 1'b0;
            mtog_q <= 1'b0;
            mdo_q  <= 1'b0;
            mdoe_q <= 1'b0;
            mwdata_q <= 16'h0000;
        end else begin
            case (mst_q)
                EGRX_M_IDLE: begin
                    mdoe_q <= 1'b0;
                    if (mdio_i) begin
                        if (mcnt_q != `EGRX_PRE_LAST) begin
                            mcnt_q <= mcnt_q + 5'h01;
                        end
                    end else if (mcnt_q == `EGRX_PRE_LAST) begin
                        mst_q  <= EGRX_M_HDR;
                        mcnt_q <= 5'h00;
                    end else begin
                        mcnt_q <= 5'h00;
                    end
                end
                EGRX_M_HDR: begin
                    msh_q  <= {msh_q[14:0], mdio_i};
                    mcnt_q <= mcnt_q + 5'h01;
                    if (mcnt_q == `EGRX_HDR_LAST) begin
                        mcnt_q <= 5'h00;
                        mreg_q <= hdr_w[4:0];
                        hit_q  <= (hdr_w[9:5] == pad_s2);
                        if (hdr_w[9:5] != pad_s2) begin
                            mst_q <= EGRX_M_SKIP;
                        end else if (hdr_w[11:10] == `EGRX_OP_RD) begin
                            mst_q <= EGRX_M_RD;
                            msh_q <= 16'h0000;
                            if (hdr_w[4:0] == `EGRX_M_CTRL) begin
                                msh_q[`EGRX_MB_ISO] <= lvl_s2[0];
                                msh_q[`EGRX_MB_UNI] <= lvl_s2[1];
                            end else if (hdr_w[4:0] == `EGRX_M_STAT) begin
                                msh_q[`EGRX_MB_LINK] <= lvl_s2[2];
                            end
                        end else if (hdr_w[11:10] == `EGRX_OP_WR) begin
                            mst_q <= EGRX_M_WR;
                        end else begin
                            mst_q <= EGRX_M_SKIP;
                        end
                    end
                end
                EGRX_M_RD: begin
                    mcnt_q <= mcnt_q + 5'h01;
                    mdoe_q <= 1'b1;
                    if (mcnt_q == 5'h00) begin
                        mdo_q <= 1'b0;
                    end else if (mcnt_q == `EGRX_DAT_LAST) begin
                        mdoe_q <= 1'b0;
                        mst_q  <= EGRX_M_IDLE;
                        mcnt_q <= 5'h00;
                    end else begin
                        mdo_q <= msh_q[15];
                        msh_q <= {msh_q[14:0], 1'b0};
                    end
                end
                EGRX_M_WR: begin
                    mcnt_q <= mcnt_q + 5'h01;
                    if (mcnt_q > `EGRX_TA_LAST) begin
                        msh_q <= {msh_q[14:0], mdio_i};
                    end
                    if (mcnt_q == `EGRX_DAT_LAST) begin
                        mwdata_q <= {msh_q[14:0], mdio_i};
                        mtog_q   <= ~mtog_q;
                        mst_q    <= EGRX_M_IDLE;
                        mcnt_q   <= 5'h00;
                    end
                end
                EGRX_M_SKIP: begin
                    mcnt_q <= mcnt_q + 5'h01;
                    if (mcnt_q == `EGRX_DAT_LAST) begin
                        mst_q  <= EGRX_M_IDLE;
                        mcnt_q <= 5'h00;
                    end
                end
                default: mst_q <= EGRX_M_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    chk_rx_out_reg: assert property (
        @(posedge core_clk) disable iff (srst)
        !$past(iso_q) |-> gmii_rx == $past(pcs_rx))
        else $error("receive output not the registered input");
    chk_clk_oe_pair: assert property (
        @(posedge core_clk) disable iff (srst)
        gmii_rx_clk_oe == gmii_rx_oe && !clk_rise_q)
        else $error("forwarded clock not paired with data");
    chk_clk_invert: assert property (
        @(posedge core_clk) disable iff (srst)
        $past(!srst, 2) |-> gmii_rx_clk)
        else $error("forwarded clock not inverted");
    chk_tx_gate: assert property (
        @(posedge core_clk) disable iff (srst)
        pcs_tx.en |-> $past(link_w || uni_q) && !$past(iso_q))
        else $error("transmit passed without link");
    chk_iso_reset: assert property (
        @(posedge core_clk) disable iff (srst)
        $past(srst) |-> iso_q && !gmii_rx_oe)
        else $error("isolate not set after reset");
    chk_iso_release: assert property (
        @(posedge core_clk) disable iff (srst)
        $past(iso_q) |-> !gmii_rx_oe && gmii_rx == '0 && !gmii_rx_clk_oe)
        else $error("outputs driven while isolated");
    chk_status_bits: assert property (
        @(posedge core_clk) disable iff (srst)
        ##1 status_vec[1] |-> status_vec[0] && $past(link_w))
        else $error("link shown without sync");
    chk_sd_loss: assert property (
        @(posedge core_clk) disable iff (srst)
        !sd_s2 ##1 1'b1 |=> !status_vec[0])
        else $error("sync kept without optical presence");
    chk_mdio_hit: assert property (@(posedge mdc) disable iff (mrst_q)
        mdio_oe |-> hit_q && mst_q == EGRX_M_RD)
        else $error("management answer without address match");

    cov_sync_up: cover property (@(posedge core_clk) disable iff (srst)
        status_vec == 2'h3);
    cov_rx_frame: cover property (@(posedge core_clk) disable iff (srst)
        gmii_rx_oe && gmii_rx.dv);
    cov_mdio_read: cover property (@(posedge mdc) disable iff (mrst_q)
        $fell(mdio_oe));
    cov_mdio_write: cover property (@(posedge core_clk) disable iff (srst)
        tog_s2 != tog_s3);

endmodule

// ### bench/egrx_mac_model.sv
/*
 * Receiving MAC at the far end of the external GMII receive pins.
 * Assumes the forwarded clock rises in the middle of each data window and
 * that the pins carry nothing meaningful while their enables are low.
 */
`timescale 1ns/1ns
module egrx_mac_model
    import egrx_pkg::*;
(
    input wire logic       rx_clk,
    input wire logic       rx_clk_oe,
    input wire egrx_gmii_s rx,
    input wire logic       rx_oe
);
    // ======================================================================
    // Capture
    // ======================================================================
    logic [8:0] got_q[$];

    // Bytes are taken on the forwarded clock's rise, and only from pins
    // that are actually driven.
    always @(posedge rx_clk) begin
        if (rx_clk_oe && rx_oe && rx.dv) begin
            got_q.push_back({rx.er, rx.data});
        end
    end
endmodule

// ### bench/external_gmii_rx_forwarding_tb.sv
/*
 * Self-checking bench of the external receive GMII block with a MAC model.
 * Assumes the design package and constants header are compiled first.
 */
`timescale 1ns/1ns
`include "egrx_map.svh"
module external_gmii_rx_forwarding_tb
    import egrx_pkg::*;
;
    logic        core_clk      = 1'b0;
    logic        srst          = 1'b1;
    egrx_gmii_s  pcs_rx        = '0;
    logic        comma_det     = 1'b0;
    logic        code_err      = 1'b0;
    logic        signal_detect = 1'b1;
    egrx_tx_s    mac_tx        = '0;
    logic [3:0]  reg_addr      = 4'h0;
    logic [15:0] reg_wdata     = 16'h0000;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic        mdc           = 1'b0;
    logic        sta_oe        = 1'b0;
    logic        sta_d         = 1'b1;
    logic [4:0]  phyad         = 5'h00;
    egrx_tx_s    pcs_tx;
    egrx_gmii_s  gmii_rx;
    logic        gmii_rx_oe;
    logic        gmii_rx_clk;
    logic        gmii_rx_clk_oe;
    logic [1:0]  status_vec;
    logic [15:0] reg_rdata;
    logic        mdio_o;
    logic        mdio_oe;
    wire         mdio_line;
    int          errors = 0;
    int          checks = 0;
    logic [8:0]  exp_q[$];

    // The management line has a pull-up when nobody drives it.
    assign mdio_line = mdio_oe ? mdio_o : (sta_oe ? sta_d : 1'b1);

    always #4 core_clk = ~core_clk;

    egrx_top DUT (
        .core_clk(core_clk), .srst(srst), .pcs_rx(pcs_rx),
        .comma_det(comma_det), .code_err(code_err), .an_enable(1'b0),
        .an_complete(1'b0), .signal_detect(signal_detect),
        .mac_tx(mac_tx), .pcs_tx(pcs_tx), .gmii_rx(gmii_rx),
        .gmii_rx_oe(gmii_rx_oe), .gmii_rx_clk(gmii_rx_clk),
        .gmii_rx_clk_oe(gmii_rx_clk_oe), .status_vec(status_vec),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc),
        .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .phyad(phyad)
    );

    egrx_mac_model mac (
        .rx_clk(gmii_rx_clk), .rx_clk_oe(gmii_rx_clk_oe),
        .rx(gmii_rx), .rx_oe(gmii_rx_oe)
    );

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rx_stream(input int n, input bit iso);
        egrx_gmii_s v;
        repeat (n) begin
            @(posedge core_clk);
            v = egrx_gmii_s'(10'($urandom));
            pcs_rx <= v;
            if (v.dv && !iso) exp_q.push_back({v.er, v.data});
            #1;
            if (iso) check({5'h0, gmii_rx_oe, gmii_rx}, 16'h0, "iso rx");
        end
        @(posedge core_clk);
        pcs_rx <= '0;
        repeat (3) @(posedge core_clk);
        check(16'(mac.got_q.size()), 16'(exp_q.size()), "byte count");
        for (int i = 0; i < exp_q.size(); i++) begin
            check(16'(mac.got_q[i]), 16'(exp_q[i]), "rx byte");
        end
        exp_q.delete();
        mac.got_q.delete();
    endtask

    task automatic clk_check(input logic oe);
        repeat (4) begin
            @(posedge core_clk);
            #2 check(gmii_rx_clk, 1'b0, "fwd clk low");
            @(negedge core_clk);
            #2 check(gmii_rx_clk, 1'b1, "fwd clk high");
            check({gmii_rx_clk_oe, gmii_rx_oe}, {oe, oe}, "rx oe");
        end
    endtask

    task automatic tx_check(input bit pass);
        egrx_tx_s v;
        repeat (4) begin
            @(posedge core_clk);
            v = egrx_tx_s'(10'($urandom));
            mac_tx <= v;
            @(posedge core_clk);
            #1 check(pcs_tx, pass ? 16'(v) : 16'h0, "pcs tx");
        end
    endtask

    task automatic commas();
        @(posedge core_clk);
        comma_det <= 1'b1;
        repeat (3) @(posedge core_clk);
        comma_det <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // Data change while the management clock is low.
    task automatic mdio_bit(input logic b);
        sta_d = b;
        #15 mdc = 1'b1;
        #15 mdc = 1'b0;
    endtask

    // Preamble, start zero and header, all driven by the station.
    task automatic mdio_head(input logic [1:0] op, input logic [4:0] ad,
                             input logic [4:0] rg);
        logic [11:0] hdr;
        hdr    = {op, ad, rg};
        sta_oe = 1'b1;
        repeat (32) mdio_bit(1'b1);
        mdio_bit(1'b0);
        for (int i = 11; i >= 0; i--) mdio_bit(hdr[i]);
    endtask

    task automatic mdio_write(input logic [4:0] ad, input logic [15:0] v);
        mdio_head(`EGRX_OP_WR, ad, `EGRX_M_CTRL);
        mdio_bit(1'b1);
        mdio_bit(1'b0);
        for (int i = 15; i >= 0; i--) mdio_bit(v[i]);
        sta_oe = 1'b0;
    endtask

    task automatic mdio_read(input logic [4:0] ad, output logic [15:0] d,
                             output logic seen_oe);
        seen_oe = 1'b0;
        d       = 16'h0;
        mdio_head(`EGRX_OP_RD, ad, `EGRX_M_STAT);
        sta_oe = 1'b0;
        for (int i = 0; i < 18; i++) begin
            #15 mdc = 1'b1;
            #15 mdc = 1'b0;
            if (i < 17) seen_oe = seen_oe | mdio_oe;
            if (i >= 1 && i <= 16) d = {d[14:0], mdio_line};
        end
        check(mdio_oe, 1'b0, "mdio released");
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        logic [15:0] d;
        logic        o;
        void'($urandom(32'h2d921a6f));
        fork
            repeat (4) mdio_bit(1'b1);
            repeat (16) @(posedge core_clk);
        join
        srst  <= 1'b0;
        phyad <= 5'($urandom);
        // The management side leaves its own reset on these edges.
        repeat (3) mdio_bit(1'b1);
        #1;
        check(status_vec, 2'b00, "status after reset");
        check(gmii_rx_oe, 1'b0, "oe after reset");
        reg_read(`EGRX_A_CTRL, d);
        check(d, {14'h0, `EGRX_UNI_RST, `EGRX_ISO_RST}, "ctrl reset");
        reg_read(4'h5, d);
        check(d, 16'h0000, "unmapped read");
        reg_write(`EGRX_A_CTRL, 16'h0003);
        rx_stream(12, 1'b1);
        tx_check(1'b0);
        clk_check(1'b0);
        reg_write(`EGRX_A_CTRL, 16'h0000);
        repeat (3) @(posedge core_clk);
        clk_check(1'b1);
        rx_stream(24, 1'b0);
        tx_check(1'b0);
        reg_write(`EGRX_A_CTRL, 16'h0002);
        tx_check(1'b1);
        reg_write(`EGRX_A_CTRL, 16'h0000);
        signal_detect <= 1'b0;
        repeat (4) @(posedge core_clk);
        commas();
        check(status_vec, 2'b00, "no light");
        @(posedge core_clk);
        signal_detect <= 1'b1;
        repeat (4) @(posedge core_clk);
        commas();
        check(status_vec, 2'b11, "link up");
        reg_read(`EGRX_A_STAT, d);
        check(d, 16'h0007, "status reg");
        tx_check(1'b1);
        mdio_read(phyad, d, o);
        check(o, 1'b1, "mdio answered");
        check(d[`EGRX_MB_LINK], 1'b1, "mdio link bit");
        mdio_read(phyad ^ 5'h01, d, o);
        check(o, 1'b0, "foreign address");
        mdio_write(phyad, 16'h0400);
        repeat (4) @(posedge core_clk);
        #1 check(gmii_rx_oe, 1'b0, "mdio isolate");
        reg_read(`EGRX_A_CTRL, d);
        check(d, 16'h0001, "mdio ctrl write");
        @(posedge core_clk);
        code_err <= 1'b1;
        @(posedge core_clk);
        code_err <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 check(status_vec, 2'b00, "sync lost");
        end_sim();
    end
endmodule
